// >>> design/rstc_pkg.sv
package rstc_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int EXT_MIN_PULSE_NS = 1500;
    // least time: round up to whole cycles
    localparam int EXT_MIN_PULSE_CYC = (EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TOUT_SHORT_NS = 150;
    localparam int TOUT_MID_US = 4100;
    localparam int TOUT_LONG_US = 65000;
    localparam int TOUT_SHORT_CYC = (TOUT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TOUT_MID_CYC_DEF = (TOUT_MID_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TOUT_LONG_CYC_DEF = (TOUT_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 22;
    localparam int EXT_CNT_W = 7;

    // clock select fuse encodings
    localparam logic [1:0] FUSE_SEL_SHORT = 2'h0;
    localparam logic [1:0] FUSE_SEL_MID = 2'h1;

    // register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CAUSE = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CLEAR = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_ENABLE = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h10;

    // reset cause bit positions
    localparam int FLAG_POR = 0;
    localparam int FLAG_EXT = 1;
    localparam int FLAG_BOD = 2;
    localparam int FLAG_WDT = 3;
    localparam int FLAG_DBG = 4;
    localparam int NFLAGS = 5;
    // event bit for reset release, after the five cause events
    localparam int EVT_RELEASE = 5;
    localparam int NEVT = 6;

    // values after reset
    localparam logic [NFLAGS-1:0] CAUSE_POR_VAL = 5'h01;
    localparam logic [NEVT-1:0] EVT_RST_VAL = 6'h00;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_COUNT = 2'b01,
        ST_RUN = 2'b11
    } rst_state_t;

endpackage

// >>> design/level_sync.sv
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // levels in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;

endmodule

`default_nettype wire

// >>> design/system_reset_controller.sv
// Summary of operation
// - reset loads I/O initial values, fetch vector
// - ports forced asynchronously by every source but the watchdog
// - fuse-selected delay stretches reset after release
// - five sources ORed into internal reset
// - power-on detector low asserts reset
// - external pin low resets; only a long enough pulse sets its flag
// - enabled watchdog timeout resets
// - brown-out resets only when detector enabled
// - debug reset register one holds reset
// - watchdog pulse one cycle, count after
// - cause flags set, zero-write clears, por
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module system_reset_controller import rstc_pkg::*; #(
    parameter int unsigned TOUT_MID_CYC = TOUT_MID_CYC_DEF,
    parameter int unsigned TOUT_LONG_CYC = TOUT_LONG_CYC_DEF
) (
    // clock and bus reset
    input wire logic CLK,
    input wire logic RST_B,
    // reset sources
    input wire logic POWER_ON_LOW,
    input wire logic BROWNOUT_LOW,
    input wire logic BROWNOUT_EN,
    input wire logic EXT_RESET_B,
    input wire logic WDT_EN,
    input wire logic WDT_TIMEOUT,
    input wire logic DEBUG_RESET_REG,
    input wire logic [1:0] CLOCK_SELECT_FUSES,
    // reset outputs
    output logic CORE_RESET,
    output logic PORT_RESET_B,
    output logic FETCH_START,
    output logic [15:0] FETCH_ADDR,
    output logic IRQ,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [ADDR_W-1:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP
);

    logic bod_active;
    logic src_async;
    logic arst_b;
    logic flag_arst_b;
    assign bod_active = BROWNOUT_EN & BROWNOUT_LOW;
    assign src_async = POWER_ON_LOW | bod_active | ~EXT_RESET_B | DEBUG_RESET_REG;
    // watchdog is synchronous; its pulse reaches the FSM through wdt_pulse_r
    assign arst_b = RST_B & ~src_async;
    // power-on clears all but its own
    assign flag_arst_b = RST_B & ~POWER_ON_LOW;

    // synchronised copies for flags and fuse selection
    logic [4:0] sync_in;
    logic [4:0] sync_out;
    logic ext_low_s;
    logic bod_s;
    logic dbg_s;
    logic [1:0] fuse_s;
    assign sync_in = {CLOCK_SELECT_FUSES, DEBUG_RESET_REG, bod_active, ~EXT_RESET_B};
    assign ext_low_s = sync_out[0];
    assign bod_s = sync_out[1];
    assign dbg_s = sync_out[2];
    assign fuse_s = sync_out[4:3];

    level_sync #(.W(5)) u_sync (
        .clk(CLK),
        .rst_b(RST_B),
        .d(sync_in),
        .q(sync_out)
    );

    // release synchroniser: asserts at once, releases on the clock
    logic rel_meta_r;
    logic rel_r;
    always_ff @(posedge CLK or negedge arst_b) begin
        if (!arst_b) begin
            rel_meta_r <= 1'b0;
            rel_r <= 1'b0;
        end else begin
            rel_meta_r <= 1'b1;
            rel_r <= rel_meta_r;
        end
    end

    logic wdt_seen_r;
    logic wdt_pulse_r;
    logic wdt_hit;
    assign wdt_hit = WDT_EN & WDT_TIMEOUT;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            wdt_seen_r <= 1'b0;
            wdt_pulse_r <= 1'b0;
        end else begin
            wdt_seen_r <= wdt_hit;
            wdt_pulse_r <= wdt_hit & ~wdt_seen_r;
        end
    end

    logic [EXT_CNT_W-1:0] ext_cnt_r;
    logic ext_long;
    assign ext_long = (ext_cnt_r == EXT_CNT_W'(EXT_MIN_PULSE_CYC));
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ext_cnt_r <= '0;
        end else if (!ext_low_s) begin
            ext_cnt_r <= '0;
        end else if (!ext_long) begin
            ext_cnt_r <= ext_cnt_r + 1'b1;
        end
    end

    // delay counter state machine
    logic src_active;
    logic [CNT_W-1:0] tout_sel;
    rst_state_t state_r;
    rst_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] tout_r;
    logic done;
    assign src_active = ~rel_r | wdt_pulse_r;
    assign tout_sel = (fuse_s == FUSE_SEL_SHORT) ? CNT_W'(TOUT_SHORT_CYC) :
                      (fuse_s == FUSE_SEL_MID) ? CNT_W'(TOUT_MID_CYC) : CNT_W'(TOUT_LONG_CYC);
    assign done = (state_r == ST_COUNT) && !src_active && (cnt_r == CNT_W'(1));

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_HOLD: begin
                cnt_nxt = tout_sel;
                if (!src_active) begin
                    state_nxt = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (src_active) begin
                    state_nxt = ST_HOLD;
                end else if (done) begin
                    state_nxt = ST_RUN;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_RUN: begin
                if (src_active) begin
                    state_nxt = ST_HOLD;
                end
            end
            default: begin
                state_nxt = ST_HOLD;
            end
        endcase
    end

    // async reset from every source but the watchdog so the stretch restarts from scratch
    always_ff @(posedge CLK or negedge arst_b) begin
        if (!arst_b) begin
            state_r <= ST_HOLD;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge CLK or negedge arst_b) begin
        if (!arst_b) begin
            tout_r <= '0;
        end else if (state_r == ST_HOLD) begin
            tout_r <= tout_sel;
        end
    end

    // watchdog pulse resets at once
    // the pulse shows in the same cycle; the state machine follows one edge later
    assign CORE_RESET = src_async | wdt_pulse_r | (state_r != ST_RUN);
    assign PORT_RESET_B = ~CORE_RESET;

    // fetch from reset vector on release
    logic fetch_r;
    logic [15:0] fetch_addr_r;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            fetch_r <= 1'b0;
            fetch_addr_r <= RESET_VECTOR_ADDR;
        end else begin
            fetch_r <= done;
            fetch_addr_r <= RESET_VECTOR_ADDR;
        end
    end
    assign FETCH_START = fetch_r;
    assign FETCH_ADDR = fetch_addr_r;

    // AHB-Lite slave: writes take no wait, reads one wait state
    logic acc;
    logic wr_pend_r;
    logic rd_wait_r;
    logic [ADDR_W-1:0] addr_r;
    logic [31:0] hrdata_r;
    logic wr_cause;
    logic wr_clear;
    logic wr_enable;
    assign acc = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
    assign wr_cause = wr_pend_r && (addr_r == ADDR_CAUSE);
    assign wr_clear = wr_pend_r && (addr_r == ADDR_CLEAR);
    assign wr_enable = wr_pend_r && (addr_r == ADDR_ENABLE);

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_pend_r <= 1'b0;
            rd_wait_r <= 1'b0;
            addr_r <= '0;
        end else begin
            wr_pend_r <= acc && HWRITE;
            rd_wait_r <= acc && !HWRITE;
            if (acc) begin
                addr_r <= HADDR;
            end
        end
    end

    // cause flags, status, enable
    logic [NFLAGS-1:0] cause_r;
    logic [NFLAGS-1:0] cause_set;
    logic [NFLAGS-1:0] cause_nxt;
    logic [NEVT-1:0] status_r;
    logic [NEVT-1:0] status_nxt;
    logic [NEVT-1:0] enable_r;
    logic [NEVT-1:0] evt;
    assign cause_set = {dbg_s, wdt_pulse_r, bod_s, ext_long, 1'b0};
    assign cause_nxt = ((wr_cause ? (cause_r & HWDATA[NFLAGS-1:0]) : cause_r)) | cause_set;
    assign evt = {fetch_r, cause_set};
    assign status_nxt = (wr_clear ? (status_r & ~HWDATA[NEVT-1:0]) : status_r) | evt;

    always_ff @(posedge CLK or negedge flag_arst_b) begin
        if (!flag_arst_b) begin
            cause_r <= CAUSE_POR_VAL;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            status_r <= EVT_RST_VAL;
            enable_r <= EVT_RST_VAL;
        end else begin
            status_r <= status_nxt;
            if (wr_enable) begin
                enable_r <= HWDATA[NEVT-1:0];
            end
        end
    end

    assign IRQ = |(status_r & enable_r);

    logic [31:0] rd_mux;
    assign rd_mux = (addr_r == ADDR_CAUSE) ? {27'h0, cause_r} :
                    (addr_r == ADDR_STATUS) ? {26'h0, status_r} :
                    (addr_r == ADDR_ENABLE) ? {26'h0, enable_r} :
                    (addr_r == ADDR_STATE) ? {28'h0, fuse_s, state_r} : 32'h0;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            hrdata_r <= 32'h0;
        end else if (rd_wait_r) begin
            hrdata_r <= rd_mux;
        end
    end

    assign HRDATA = hrdata_r;
    assign HREADYOUT = ~rd_wait_r;
    assign HRESP = HRESP_OKAY;

    // checks
    logic [CNT_W-1:0] stretch_r;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            stretch_r <= '0;
        end else if (state_r == ST_COUNT) begin
            stretch_r <= stretch_r + 1'b1;
        end else begin
            stretch_r <= '0;
        end
    end

    property p_stretch;
        @(posedge CLK) disable iff (!RST_B)
        (state_r == ST_COUNT) ##1 (state_r == ST_RUN) |-> (stretch_r == tout_r);
    endproperty
    a_stretch: assert property (p_stretch) else $error("reset stretch length differs from time-out");

    property p_fetch;
        @(posedge CLK) disable iff (!RST_B)
        $rose(state_r == ST_RUN) |-> FETCH_START && (FETCH_ADDR == RESET_VECTOR_ADDR) ##1 !FETCH_START;
    endproperty
    a_fetch: assert property (p_fetch) else $error("no single fetch pulse at reset vector");

    property p_por;
        @(posedge CLK) disable iff (!RST_B)
        POWER_ON_LOW |-> CORE_RESET && !PORT_RESET_B && (cause_r == CAUSE_POR_VAL);
    endproperty
    a_por: assert property (p_por) else $error("power-on did not reset or clear flags");

    property p_bod;
        @(posedge CLK) disable iff (!RST_B)
        (BROWNOUT_LOW && !BROWNOUT_EN && (state_r == ST_RUN) && !src_async && !wdt_pulse_r) |=> (state_r == ST_RUN);
    endproperty
    a_bod: assert property (p_bod) else $error("disabled brown-out caused reset");

    property p_bod_on;
        @(posedge CLK) disable iff (!RST_B)
        (BROWNOUT_LOW && BROWNOUT_EN) |-> !PORT_RESET_B ##3 cause_r[FLAG_BOD] || !BROWNOUT_EN || !BROWNOUT_LOW;
    endproperty
    a_bod_on: assert property (p_bod_on) else $error("brown-out did not reset");

    property p_wdt;
        @(posedge CLK) disable iff (!RST_B)
        wdt_pulse_r |-> (state_nxt == ST_HOLD) ##1 (!wdt_pulse_r && cause_r[FLAG_WDT]);
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog pulse not one cycle or not flagged");

    property p_ext;
        @(posedge CLK) disable iff (!RST_B)
        ext_long |=> cause_r[FLAG_EXT];
    endproperty
    a_ext: assert property (p_ext) else $error("long external pulse not flagged");

    property p_dbg;
        @(posedge CLK) disable iff (!RST_B)
        dbg_s |-> CORE_RESET && (state_r != ST_RUN);
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug reset register did not hold reset");

    property p_clear;
        @(posedge CLK) disable iff (!RST_B || POWER_ON_LOW)
        (wr_cause && !HWDATA[FLAG_EXT] && !ext_long) |=> !cause_r[FLAG_EXT];
    endproperty
    a_clear: assert property (p_clear) else $error("zero write did not clear flag");

endmodule

`default_nettype wire

// >>> testbench/rst_src_model.sv
`timescale 1ns/1ps
`default_nettype none

module rst_src_model (
    // clock
    input wire logic clk,
    // detector and pin levels
    output logic por_low,
    output logic bod_low,
    output logic bod_en,
    output logic ext_b,
    // watchdog and debug port
    output logic wdt_en,
    output logic wdt_to,
    output logic dbg
);
    initial begin
        por_low = 1'b0;
        bod_low = 1'b0;
        bod_en = 1'b1;
        ext_b = 1'b1;
        wdt_en = 1'b1;
        wdt_to = 1'b0;
        dbg = 1'b0;
    end

    // debug bit held as a level
    task automatic drive(input int s, input logic v);
        case (s)
            0: por_low <= v;
            1: ext_b <= !v;
            2: bod_low <= v;
            4: dbg <= v;
            default: ;
        endcase
    endtask

    task automatic fire();
        wdt_to <= 1'b1;
        @(posedge clk);
        wdt_to <= 1'b0;
    endtask
endmodule

`default_nettype wire

// >>> testbench/system_reset_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none

module system_reset_controller_tb import rstc_pkg::*;;
    logic CLK = 1'b0;
    logic RST_B;
    logic [1:0] CLOCK_SELECT_FUSES;
    logic HSEL = 1'b1;
    logic [ADDR_W-1:0] HADDR;
    logic [1:0] HTRANS;
    logic HWRITE;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HWDATA;
    wire logic [31:0] HRDATA;
    wire logic HREADYOUT, HRESP, CORE_RESET, PORT_RESET_B, FETCH_START, IRQ;
    wire logic [15:0] FETCH_ADDR;
    wire logic por_low, bod_low, bod_en, ext_b, wdt_en, wdt_to, dbg;
    logic [31:0] rd;
    int fail_count = 0;
    int n_tests = 0;

    always #12.5 CLK = ~CLK;

    rst_src_model src (.clk(CLK), .por_low(por_low), .bod_low(bod_low), .bod_en(bod_en),
        .ext_b(ext_b), .wdt_en(wdt_en), .wdt_to(wdt_to), .dbg(dbg));

    // short mid and long counts keep the run brief
    system_reset_controller #(.TOUT_MID_CYC(20), .TOUT_LONG_CYC(40)) uut (
        .CLK(CLK), .RST_B(RST_B), .POWER_ON_LOW(por_low), .BROWNOUT_LOW(bod_low),
        .BROWNOUT_EN(bod_en), .EXT_RESET_B(ext_b), .WDT_EN(wdt_en), .WDT_TIMEOUT(wdt_to),
        .DEBUG_RESET_REG(dbg), .CLOCK_SELECT_FUSES(CLOCK_SELECT_FUSES),
        .CORE_RESET(CORE_RESET), .PORT_RESET_B(PORT_RESET_B), .FETCH_START(FETCH_START),
        .FETCH_ADDR(FETCH_ADDR), .IRQ(IRQ), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP));

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic final_report();
        if (fail_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // single word transfer; read data lands in rd
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        HADDR <= a;
        HTRANS <= HTRANS_NONSEQ;
        HWRITE <= w;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
        check(HRESP, HRESP_OKAY);
    endtask

    task automatic wait_run(input int t);
        int n;
        n = 0;
        do begin
            @(posedge CLK);
            #1;
            n++;
        end while (CORE_RESET === 1'b1 && n < 300);
        check(n >= t && n <= t + 4, 1);
        check({FETCH_START, FETCH_ADDR}, {1'b1, RESET_VECTOR_ADDR});
        check(PORT_RESET_B, 1);
    endtask

    task automatic fuses();
        int tt [4] = '{6, 20, 40, 40};
        for (int i = 0; i < 4; i++) begin
            RST_B <= 1'b0;
            CLOCK_SELECT_FUSES <= 2'(i);
            repeat (3) @(posedge CLK);
            RST_B <= 1'b1;
            wait_run(tt[i]);
            bus(ADDR_STATE, 0, 0);
            check(rd, {28'h0, 2'(i), 2'b11});
            bus(ADDR_CAUSE, 0, 0);
            check(rd, 32'(CAUSE_POR_VAL));
        end
        CLOCK_SELECT_FUSES <= FUSE_SEL_SHORT;
        RST_B <= 1'b0;
        repeat (3) @(posedge CLK);
        RST_B <= 1'b1;
        wait_run(6);
    endtask

    task automatic sources();
        int s [4] = '{FLAG_EXT, FLAG_BOD, FLAG_DBG, FLAG_POR};
        logic [31:0] e;
        bus(ADDR_CAUSE, 1, 0);
        bus(ADDR_CAUSE, 0, 0);
        check(rd, 0);
        // a short pin pulse still resets but leaves no flag
        src.drive(FLAG_EXT, 1);
        #1 check(CORE_RESET, 1);
        repeat (10) @(posedge CLK);
        src.drive(FLAG_EXT, 0);
        wait_run(6);
        bus(ADDR_CAUSE, 0, 0);
        check(rd, 0);
        e = 0;
        for (int i = 0; i < 4; i++) begin
            src.drive(s[i], 1);
            #1 check(CORE_RESET, 1);
            check(PORT_RESET_B, 0);
            repeat (70) @(posedge CLK);
            src.drive(s[i], 0);
            wait_run(6);
            e = (s[i] == FLAG_POR) ? 32'h1 : e | (32'h1 << s[i]);
            bus(ADDR_CAUSE, 0, 0);
            check(rd, e);
        end
        src.bod_en <= 1'b0;
        src.drive(FLAG_BOD, 1);
        repeat (3) @(posedge CLK);
        #1 check(CORE_RESET, 0);
        src.drive(FLAG_BOD, 0);
        src.bod_en <= 1'b1;
    endtask

    task automatic wdog();
        src.wdt_en <= 1'b0;
        src.fire();
        repeat (2) @(posedge CLK);
        #1 check(CORE_RESET, 0);
        src.wdt_en <= 1'b1;
        @(posedge CLK);
        src.fire();
        #1 check(CORE_RESET, 1);
        wait_run(6);
        bus(ADDR_CAUSE, 0, 0);
        check(rd, 32'h09);
        bus(ADDR_CAUSE, 1, 32'h08);
        bus(ADDR_CAUSE, 0, 0);
        check(rd, 32'h08);
    endtask

    task automatic irq();
        bus(ADDR_CLEAR, 1, 32'h3f);
        bus(ADDR_STATUS, 0, 0);
        check(rd, 0);
        bus(ADDR_ENABLE, 1, 32'h1 << FLAG_EXT);
        #1 check(IRQ, 0);
        src.drive(FLAG_EXT, 1);
        repeat (70) @(posedge CLK);
        src.drive(FLAG_EXT, 0);
        wait_run(6);
        repeat (2) @(posedge CLK);
        #1 check(IRQ, 1);
        bus(ADDR_STATUS, 0, 0);
        check(rd, (32'h1 << FLAG_EXT) | (32'h1 << EVT_RELEASE));
        bus(ADDR_ENABLE, 1, 0);
        #1 check(IRQ, 0);
        bus(ADDR_ENABLE, 1, 32'h1 << EVT_RELEASE);
        #1 check(IRQ, 1);
        bus(ADDR_CLEAR, 1, 32'h1 << EVT_RELEASE);
        #1 check(IRQ, 0);
        bus(ADDR_ENABLE, 0, 0);
        check(rd, 32'h20);
        // unmapped place reads as zero
        bus(8'h20, 0, 0);
        check(rd, 0);
    endtask

    initial begin
        RST_B = 1'b0;
        CLOCK_SELECT_FUSES = FUSE_SEL_SHORT;
        HADDR = 0;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HWDATA = 0;
        repeat (2) @(posedge CLK);
        RST_B <= 1'b1;
        // software jumps from the vector fetched here
        wait_run(6);
        fuses();
        sources();
        wdog();
        irq();
        final_report();
    end

    initial begin
        #(25 * 20000);
        fail_count++;
        final_report();
    end
endmodule

`default_nettype wire
